// ### rtl/adc_event_irq_enable.sv
`timescale 1ns/100ps
`default_nettype none
// Interrupt enable set/clear logic for the converter events
module adc_event_irq_enable
    import irq_enable_pkg::*;
(
    input wire logic clock, // Core clock, 200 MHz
    input wire logic resetn, // Synchronous reset, active low
    input wire logic [irq_enable_pkg::ADDR_W-1:0] addr, // Byte address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [31:0] rdata, // Read data, one cycle after strobe
    input wire logic [irq_enable_pkg::EVENT_COUNT-1:0] events, // Event pulses
    output logic irq // Any enabled event present
);
    import irq_enable_pkg::*;

    logic [EVENT_COUNT-1:0] enable_vec;
    logic [EVENT_COUNT-1:0] req_vec;
    logic [EVENT_COUNT-1:0] set_vec;
    logic [EVENT_COUNT-1:0] clear_vec;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    access_e acc;

    // ****************************************
    // Address decode
    // ****************************************
    // Unmapped addresses decode to no access and read as zero
    always_comb
    begin
        acc = ACC_NONE;
        if (addr == ENABLE_MASK_OFFSET)
            acc = ACC_SET;
        else if (addr == DISABLE_MASK_OFFSET)
            acc = ACC_CLEAR;
    end

    // Write-one strobes per field; zeros in wdata produce no pulse
    always_comb
    begin
        set_vec = '0;
        clear_vec = '0;
        case (acc)
            ACC_SET:
            begin
                if (wr_en)
                    set_vec = wdata[EVENT_COUNT-1:0];
            end
            ACC_CLEAR:
            begin
                if (wr_en)
                    clear_vec = wdata[EVENT_COUNT-1:0];
            end
            ACC_NONE:
            begin
                set_vec = '0;
            end
            default:
            begin
                set_vec = '0;
            end
        endcase
    end

    // ****************************************
    // Per-event flags
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < EVENT_COUNT; gi++)
        begin : g_bit
            enable_bit u_bit (
                .clock(clock),
                .resetn(resetn),
                .set_pulse(set_vec[gi]),
                .clear_pulse(clear_vec[gi]),
                .event_in(events[gi]),
                .enable(enable_vec[gi]),
                .irq_req(req_vec[gi])
            );
        end
    endgenerate

    // ****************************************
    // Read path
    // ****************************************
    // Both offsets return the same shared state
    always_comb
    begin
        rdata_next = '0;
        if (rd_en && (acc != ACC_NONE))
            rdata_next = {{(32-EVENT_COUNT){1'b0}}, enable_vec};
    end

    // Data holds only in the cycle after the read strobe
    always_ff @(posedge clock)
    begin
        if (!resetn)
            rdata_reg <= '0;
        else
            rdata_reg <= rdata_next;
    end

    assign rdata = rdata_reg;
    assign irq = |req_vec;

    // ****************************************
    // Checks
    // ****************************************
    chk_clear_started: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_STARTED]) |=> !enable_vec[BIT_STARTED])
        else $error("started enable not cleared");
    chk_clear_end: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_END]) |=> !enable_vec[BIT_END])
        else $error("end enable not cleared");
    chk_clear_done: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_DONE]) |=> !enable_vec[BIT_DONE])
        else $error("done enable not cleared");
    chk_clear_result: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_RESULT]) |=> !enable_vec[BIT_RESULT])
        else $error("result enable not cleared");
    chk_clear_calib: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_CALIB]) |=> !enable_vec[BIT_CALIB])
        else $error("calibration enable not cleared");
    chk_clear_stopped: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_STOPPED])
        |=> !enable_vec[BIT_STOPPED])
        else $error("stopped enable not cleared");
    chk_clear_ch0_upper: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_CH0_UPPER])
        |=> !enable_vec[BIT_CH0_UPPER])
        else $error("chan0 upper enable not cleared");
    chk_set_ch6_lower: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_CH6_LOWER])
        |=> enable_vec[BIT_CH6_LOWER])
        else $error("chan6 lower enable not set");
    chk_set_ch7_upper: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_CH7_UPPER])
        |=> enable_vec[BIT_CH7_UPPER])
        else $error("chan7 upper enable not set");
    chk_set_ch7_lower: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_CH7_LOWER])
        |=> enable_vec[BIT_CH7_LOWER])
        else $error("chan7 lower enable not set");
    chk_read_shared: assert property (@(posedge clock) disable iff (!resetn)
        (rd_en && (addr == ENABLE_MASK_OFFSET || addr == DISABLE_MASK_OFFSET))
        |=> rdata[EVENT_COUNT-1:0] == $past(enable_vec))
        else $error("read data differs from enable state");
    chk_hold_idle: assert property (@(posedge clock) disable iff (!resetn)
        !wr_en ##1 1'b1 |-> enable_vec == $past(enable_vec))
        else $error("enable changed without a write");
    chk_irq_gate: assert property (@(posedge clock) disable iff (!resetn)
        irq == |(events & enable_vec))
        else $error("interrupt not gated by enables");

    // ****************************************
    // Reset, idle and refused accesses
    // ****************************************
    // Reset check runs without disable so the reset cycles themselves are seen
    chk_reset_clear: assert property (@(posedge clock)
        !resetn |=> (enable_vec == ENABLE_RESET) && (rdata == 32'h00000000))
        else $error("enables or read data not cleared by reset");
    // Read data must drop back to zero outside the answer cycle
    chk_rdata_idle: assert property (@(posedge clock) disable iff (!resetn)
        !rd_en |=> rdata == 32'h00000000)
        else $error("read data present without a read");
    chk_upper_zero: assert property (@(posedge clock) disable iff (!resetn)
        rdata[31:EVENT_COUNT] == '0)
        else $error("unused read bits not zero");
    // Unmapped writes must not reach any flag
    chk_hole_write: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr != ENABLE_MASK_OFFSET && addr != DISABLE_MASK_OFFSET)
        |=> enable_vec == $past(enable_vec))
        else $error("unmapped write changed enables");

    // ****************************************
    // Zero bits leave their flag alone
    // ****************************************
    // A broken strobe mask would spill a write into neighbouring fields
    chk_keep_started: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && !wdata[BIT_STARTED])
        |=> enable_vec[BIT_STARTED] == $past(enable_vec[BIT_STARTED]))
        else $error("started enable changed by zero bit");
    chk_keep_end: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && !wdata[BIT_END])
        |=> enable_vec[BIT_END] == $past(enable_vec[BIT_END]))
        else $error("end enable changed by zero bit");
    chk_keep_done: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && !wdata[BIT_DONE])
        |=> enable_vec[BIT_DONE] == $past(enable_vec[BIT_DONE]))
        else $error("done enable changed by zero bit");
    chk_keep_result: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && !wdata[BIT_RESULT])
        |=> enable_vec[BIT_RESULT] == $past(enable_vec[BIT_RESULT]))
        else $error("result enable changed by zero bit");
    chk_keep_calib: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && !wdata[BIT_CALIB])
        |=> enable_vec[BIT_CALIB] == $past(enable_vec[BIT_CALIB]))
        else $error("calibration enable changed by zero bit");
    chk_keep_stopped: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && !wdata[BIT_STOPPED])
        |=> enable_vec[BIT_STOPPED] == $past(enable_vec[BIT_STOPPED]))
        else $error("stopped enable changed by zero bit");
    chk_keep_ch0_upper: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && !wdata[BIT_CH0_UPPER])
        |=> enable_vec[BIT_CH0_UPPER] == $past(enable_vec[BIT_CH0_UPPER]))
        else $error("chan0 upper enable changed by zero bit");
    chk_keep_ch6_lower: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && !wdata[BIT_CH6_LOWER])
        |=> enable_vec[BIT_CH6_LOWER] == $past(enable_vec[BIT_CH6_LOWER]))
        else $error("chan6 lower enable changed by zero bit");
    chk_keep_ch7_upper: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && !wdata[BIT_CH7_UPPER])
        |=> enable_vec[BIT_CH7_UPPER] == $past(enable_vec[BIT_CH7_UPPER]))
        else $error("chan7 upper enable changed by zero bit");
    chk_keep_ch7_lower: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && !wdata[BIT_CH7_LOWER])
        |=> enable_vec[BIT_CH7_LOWER] == $past(enable_vec[BIT_CH7_LOWER]))
        else $error("chan7 lower enable changed by zero bit");

    // ****************************************
    // Shared flag seen from the other register
    // ****************************************
    // One flag per event: the opposite register must reach the same bit
    chk_set_started: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_STARTED])
        |=> enable_vec[BIT_STARTED])
        else $error("started enable not set");
    chk_set_end: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_END])
        |=> enable_vec[BIT_END])
        else $error("end enable not set");
    chk_set_done: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_DONE])
        |=> enable_vec[BIT_DONE])
        else $error("done enable not set");
    chk_set_result: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_RESULT])
        |=> enable_vec[BIT_RESULT])
        else $error("result enable not set");
    chk_set_calib: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_CALIB])
        |=> enable_vec[BIT_CALIB])
        else $error("calibration enable not set");
    chk_set_stopped: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_STOPPED])
        |=> enable_vec[BIT_STOPPED])
        else $error("stopped enable not set");
    chk_set_ch0_upper: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == ENABLE_MASK_OFFSET && wdata[BIT_CH0_UPPER])
        |=> enable_vec[BIT_CH0_UPPER])
        else $error("chan0 upper enable not set");
    chk_clear_ch6_lower: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_CH6_LOWER])
        |=> !enable_vec[BIT_CH6_LOWER])
        else $error("chan6 lower enable not cleared");
    chk_clear_ch7_upper: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_CH7_UPPER])
        |=> !enable_vec[BIT_CH7_UPPER])
        else $error("chan7 upper enable not cleared");
    chk_clear_ch7_lower: assert property (@(posedge clock) disable iff (!resetn)
        (wr_en && addr == DISABLE_MASK_OFFSET && wdata[BIT_CH7_LOWER])
        |=> !enable_vec[BIT_CH7_LOWER])
        else $error("chan7 lower enable not cleared");

    cov_set_then_clear: cover property (@(posedge clock) disable iff (!resetn)
        enable_vec[BIT_CH7_UPPER] ##[1:20] !enable_vec[BIT_CH7_UPPER]);
    cov_irq_fired: cover property (@(posedge clock) disable iff (!resetn) irq);
    cov_read_back: cover property (@(posedge clock) disable iff (!resetn)
        rd_en && addr == DISABLE_MASK_OFFSET ##1 rdata != 32'h00000000);
    // Write straight into a read with no idle cycle between
    cov_write_read: cover property (@(posedge clock) disable iff (!resetn) wr_en ##1 rd_en);
    cov_zero_write: cover property (@(posedge clock) disable iff (!resetn)
        wr_en && wdata == 32'h00000000);
endmodule
`default_nettype wire

// ### rtl/irq_enable_pkg.sv
// Contract
// - Clear bit A disables started interrupt
// - Clear bit B disables buffer-end interrupt
// - Clear bit C disables conversion-done interrupt
// - Clear bit D disables result-transferred interrupt
// - Clear bit E disables calibration-finished interrupt
// - Clear bit F disables converter-stopped interrupt
// - Clear bit G disables chan0 upper interrupt
// - Set bit T enables chan6 lower interrupt
// - Set bit U enables chan7 upper interrupt
// - Set bit V enables chan7 lower interrupt
package irq_enable_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int ADDR_W = 12;
    localparam int EVENT_COUNT = 22;
    localparam logic [ADDR_W-1:0] ENABLE_MASK_OFFSET = 12'h304;
    localparam logic [ADDR_W-1:0] DISABLE_MASK_OFFSET = 12'h308;
    localparam logic [EVENT_COUNT-1:0] ENABLE_RESET = 22'h000000;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_STARTED = 0;
    localparam int BIT_END = 1;
    localparam int BIT_DONE = 2;
    localparam int BIT_RESULT = 3;
    localparam int BIT_CALIB = 4;
    localparam int BIT_STOPPED = 5;
    localparam int BIT_CH0_UPPER = 6;
    localparam int BIT_CH6_LOWER = 19;
    localparam int BIT_CH7_UPPER = 20;
    localparam int BIT_CH7_LOWER = 21;

    // Access kind decoded from the address
    typedef enum logic [2:0] {
        ACC_NONE = 3'b001,
        ACC_SET = 3'b010,
        ACC_CLEAR = 3'b100
    } access_e;
endpackage

// ### rtl/enable_bit.sv
`timescale 1ns/100ps
`default_nettype none
// One event's enable flag, set and clear by write-one
module enable_bit
    import irq_enable_pkg::*;
(
    input wire logic clock, // Core clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic set_pulse, // Write of 1 to the set register
    input wire logic clear_pulse, // Write of 1 to the clear register
    input wire logic event_in, // Raw event pulse
    output logic enable, // Current enable state
    output logic irq_req // Event gated by enable
);
    logic enable_reg;
    logic enable_next;

    // ****************************************
    // Flag update
    // ****************************************
    // Set and clear never coincide: they come from two different addresses
    always_comb
    begin
        enable_next = enable_reg;
        if (set_pulse)
            enable_next = 1'b1;
        else if (clear_pulse)
            enable_next = 1'b0;
    end

    // Register only
    always_ff @(posedge clock)
    begin
        if (!resetn)
            enable_reg <= 1'b0;
        else
            enable_reg <= enable_next;
    end

    assign enable = enable_reg;
    assign irq_req = enable_reg & event_in;
endmodule
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    import irq_enable_pkg::*;
    // ****************************************
    // Stimulus and observation
    // ****************************************
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [EVENT_COUNT-1:0] events = '0;
    logic [31:0] rdata;
    logic irq;
    int bad_count = 0;
    int cmp_count = 0;
    localparam logic [ADDR_W-1:0] HOLE = 12'h300;
    localparam logic [31:0] ALL = 32'h003fffff;

    // Half period of the 200 MHz clock
    always #2.5 clock = ~clock;

    adc_event_irq_enable dut (
        .clock(clock),
        .resetn(resetn),
        .addr(addr),
        .wdata(wdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rdata(rdata),
        .events(events),
        .irq(irq)
    );

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe, released on the next edge
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    // Read data only stand in the cycle after the strobe
    task automatic rd(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check(what, exp, rdata);
    endtask

    // Irq is combinational, so look just after the events land
    task automatic ev(input logic [EVENT_COUNT-1:0] e, input logic exp);
        @(posedge clock);
        events <= e;
        #1;
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic reset_state();
        rd("set reg", ENABLE_MASK_OFFSET, 32'h0);
        rd("clr reg", DISABLE_MASK_OFFSET, 32'h0);
        ev('1, 1'b0);
        wr(ENABLE_MASK_OFFSET, 32'h0);
        rd("zero write", ENABLE_MASK_OFFSET, 32'h0);
    endtask

    // Each field alone, so a swapped bit position shows up
    task automatic single_fields();
        int list [10] = '{0, 1, 2, 3, 4, 5, 6, 19, 20, 21};
        foreach (list[k])
        begin
            wr(DISABLE_MASK_OFFSET, 32'hffffffff);
            wr(ENABLE_MASK_OFFSET, 32'h1 << list[k]);
            rd("set one", ENABLE_MASK_OFFSET, 32'h1 << list[k]);
            rd("clr one", DISABLE_MASK_OFFSET, 32'h1 << list[k]);
            ev(22'h1 << list[k], 1'b1);
            ev(~(22'h1 << list[k]), 1'b0);
        end
        @(posedge clock);
        events <= '0;
    endtask

    // Clears build up one field at a time; upper bits must stay zero
    task automatic clear_walk();
        wr(ENABLE_MASK_OFFSET, 32'hffffffff);
        rd("set all", DISABLE_MASK_OFFSET, ALL);
        for (int i = 0; i < 7; i++)
        begin
            wr(DISABLE_MASK_OFFSET, 32'h1 << i);
            rd("clr walk", DISABLE_MASK_OFFSET, ALL & ~((32'h2 << i) - 1));
        end
        wr(DISABLE_MASK_OFFSET, 32'h0);
        rd("clr zero", ENABLE_MASK_OFFSET, 32'h003fff80);
    endtask

    // Unmapped place is ignored; write then read with no gap
    task automatic hole_and_burst();
        wr(HOLE, 32'hffffffff);
        rd("hole", HOLE, 32'h0);
        rd("after hole", ENABLE_MASK_OFFSET, 32'h003fff80);
        @(posedge clock);
        addr <= DISABLE_MASK_OFFSET;
        wdata <= 32'h003fffff;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        check("burst", 32'h0, rdata);
        @(posedge clock);
        #1;
        check("rdata idle", 32'h0, rdata);
    endtask

    // A second reset in mid-run drops every enable
    task automatic mid_reset();
        wr(ENABLE_MASK_OFFSET, 32'h00380000);
        @(posedge clock);
        resetn <= 1'b0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        rd("re-reset", ENABLE_MASK_OFFSET, 32'h0);
    endtask

    task automatic print_verdict();
        if (bad_count == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (12) @(posedge clock);
        resetn <= 1'b1;
        reset_state();
        single_fields();
        clear_walk();
        hole_and_burst();
        mid_reset();
        print_verdict();
    end
endmodule
`default_nettype wire
